// *** include/option_byte_params.svh ***
`ifndef OPTION_BYTE_PARAMS_SVH
`define OPTION_BYTE_PARAMS_SVH

// Register byte addresses
`define OB_ADDR_WORD 32'h0000_0000
`define OB_ADDR_STATUS 32'h0000_0004

// Blank one-time-programmable content
`define OB_WORD_RESET 16'h0000

// Option word field positions
`define OB_BIT_EXT_STOP 9
`define OB_BIT_LOW_VOLT 8
`define OB_BIT_PROTECT 7
`define OB_BIT_RC_OSC 6
`define OB_BIT_RSVD_CLR 5
`define OB_BIT_RSVD_SET 4
`define OB_BIT_NMI_PULL 3
`define OB_BIT_CNT_PULL 2
`define OB_BIT_HW_WDG 1
`define OB_BIT_CLK_GUARD 0
`define OB_RSVD_HI_MASK 16'hfc00

// Status register field positions
`define OB_ST_PROG 0
`define OB_ST_MASK 1
`define OB_ST_REJECT 2
`define OB_ST_RSVD 3

// Bus encodings
`define OB_HSIZE_WORD 3'h2

`endif

// *** include/option_byte_pkg.sv ***
package option_byte_pkg;

   // Decoded configuration handed to the rest of the chip
   typedef struct packed {
      logic extStop;
      logic lowVoltDetect;
      logic readProtect;
      logic rcOsc;
      logic nmiPullup;
      logic counterPullup;
      logic hwWatchdog;
      logic clockGuard;
   } cfg_t;

   // Bus slave phase
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WR = 2'b01,
      ST_RDW = 2'b10,
      ST_RDD = 2'b11
   } bus_state_t;

endpackage

// *** design/otp_bit_cell.sv ***
`timescale 1ns/100ps
module otp_bit_cell (
   // Clock and power-on reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Burn request
   input wire logic burnEnable,
   input wire logic burnValue,
   // Stored bit
   output logic fuse
);

   // A cell only ever goes from blank to burnt
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fuse <= 1'b0;
      end else if (burnEnable && burnValue) begin
         fuse <= 1'b1; // R3
      end
   end

endmodule

// *** design/option_byte_config.sv ***
// Overview of operation
// R1: Programming mode only while programming pin high
// R2: Option word invisible outside programming mode
// R3: Each bit can be programmed once only
// R4: Blank part holds all bits zero
// R5: Programmer writes zeros to bits 15:10
// R6: External stop control gates stop with watchdog
// R7: Low-voltage detector enable follows its bit
// R8: Protection bit blocks external program reads
// R9: Oscillator select picks crystal or RC
// R10: Programmer writes bit5 zero, bit4 one
// R11: NMI pull-up only when its bit set
// R12: Counter pin pull-up only when bit set
// R13: Watchdog select: software or always on
// R14: Clock guard enable follows its bit
// R15: Mask variants use fixed factory code
// R16: Configuration stable outside programming mode
// R17: Reprogramming a burnt bit changes nothing
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "option_byte_params.svh"
module option_byte_config
   import option_byte_pkg::*;
#(
   parameter logic MASK_ROM = 1'b0,
   parameter logic [15:0] MASK_CODE = 16'h0010
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Programming-voltage detector
   input wire logic vppHigh,
   // Pin and watchdog state
   input wire logic nmiPinHigh,
   input wire logic softWatchdogEnable,
   // Configuration outputs
   output cfg_t cfg,
   output logic stopAllowed,
   output logic watchdogEnable,
   output logic extReadAllowed
);

   bus_state_t state;
   bus_state_t next_state;
   logic [31:0] addrReg;
   logic sizeWord;
   logic progMode;
   logic [15:0] fuseWord;
   logic [15:0] effWord;
   logic [15:0] cfgWord;
   logic progWrite;
   logic wordWrite;
   logic statusWrite;
   logic rejectFlag;
   logic reservedFlag;
   logic rsvdBad;
   logic [31:0] readMux;
   logic accept;
   logic watchdogNow;
   logic everProgrammed;
   logic settled;

   // Assertion clock and reset for every check below
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   // Programming mode follows the high-voltage detector
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         progMode <= 1'b0;
      end else begin
         progMode <= vppHigh; // R1
      end
   end

   // Address phase taken when selected, ready and NONSEQ or SEQ
   assign accept = hsel && hready && htrans[1];

   // Bus phase sequencing; reads take one wait state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RDW: next_state = ST_RDD;
         ST_IDLE, ST_WR, ST_RDD: begin
            if (accept) begin
               next_state = hwrite ? ST_WR : ST_RDW;
            end else begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Address and size captured with each accepted transfer
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         addrReg <= 32'h0000_0000;
         sizeWord <= 1'b0;
      end else if (accept && state != ST_RDW) begin
         addrReg <= haddr;
         sizeWord <= (hsize == `OB_HSIZE_WORD);
      end
   end

   assign hreadyout = (state != ST_RDW);
   assign hresp = 1'b0;

   // Write decode in the data phase
   assign wordWrite = (state == ST_WR) && sizeWord && (addrReg == `OB_ADDR_WORD);
   assign statusWrite = (state == ST_WR) && sizeWord && (addrReg == `OB_ADDR_STATUS);
   assign progWrite = wordWrite && progMode && !MASK_ROM; // R2 R15

   // One-time cells; burning only adds ones
   for (genvar i = 0; i < 16; i++) begin : g_cell
      otp_bit_cell u_cell (
         .ref_clk(ref_clk),
         .arst_n(arst_n),
         .burnEnable(progWrite),
         .burnValue(hwdata[i]),
         .fuse(fuseWord[i])
      ); // R3 R17
   end

   // Mask variants ignore the cells entirely
   assign effWord = MASK_ROM ? MASK_CODE : fuseWord; // R15

   // Configuration word held in flops for the rest of the chip
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgWord <= `OB_WORD_RESET; // R4
      end else begin
         cfgWord <= effWord; // R16
      end
   end

   // Field decode
   always_comb begin
      cfg.extStop = cfgWord[`OB_BIT_EXT_STOP];
      cfg.lowVoltDetect = cfgWord[`OB_BIT_LOW_VOLT]; // R7
      cfg.readProtect = cfgWord[`OB_BIT_PROTECT];
      cfg.rcOsc = cfgWord[`OB_BIT_RC_OSC]; // R9
      cfg.nmiPullup = cfgWord[`OB_BIT_NMI_PULL]; // R11
      cfg.counterPullup = cfgWord[`OB_BIT_CNT_PULL]; // R12
      cfg.hwWatchdog = cfgWord[`OB_BIT_HW_WDG];
      cfg.clockGuard = cfgWord[`OB_BIT_CLK_GUARD]; // R14
   end

   assign watchdogNow = cfg.hwWatchdog || softWatchdogEnable;

   // Derived controls
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stopAllowed <= 1'b0;
         watchdogEnable <= 1'b0;
         extReadAllowed <= 1'b0;
      end else begin
         stopAllowed <= !watchdogNow || (cfg.extStop && nmiPinHigh); // R6
         watchdogEnable <= watchdogNow; // R13
         extReadAllowed <= !cfg.readProtect; // R8
      end
   end

   // Reserved pattern check on programming data
   assign rsvdBad = ((hwdata[15:0] & `OB_RSVD_HI_MASK) != 16'h0000)
                    || hwdata[`OB_BIT_RSVD_CLR] || !hwdata[`OB_BIT_RSVD_SET];

   // Sticky flags, write one to clear; a new event wins
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rejectFlag <= 1'b0;
         reservedFlag <= 1'b0;
      end else begin
         rejectFlag <= (wordWrite && (!progMode || MASK_ROM))
                       || (rejectFlag && !(statusWrite && hwdata[`OB_ST_REJECT]));
         reservedFlag <= (progWrite && rsvdBad)
                         || (reservedFlag && !(statusWrite && hwdata[`OB_ST_RSVD]));
      end
   end

   // Read data selection
   always_comb begin
      readMux = 32'h0000_0000;
      if (sizeWord && addrReg == `OB_ADDR_WORD && progMode) begin
         readMux[15:0] = effWord; // R2
      end else if (sizeWord && addrReg == `OB_ADDR_STATUS) begin
         readMux[`OB_ST_PROG] = progMode;
         readMux[`OB_ST_MASK] = MASK_ROM;
         readMux[`OB_ST_REJECT] = rejectFlag;
         readMux[`OB_ST_RSVD] = reservedFlag;
      end
   end

   // Read data registered during the wait state
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (state == ST_RDW) begin
         hrdata <= readMux;
      end
   end

   // Helpers for the checks below
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         everProgrammed <= 1'b0;
         settled <= 1'b0;
      end else begin
         everProgrammed <= everProgrammed || progWrite;
         settled <= 1'b1;
      end
   end

   property p_prog_mode;
      settled |-> (progMode == $past(vppHigh));
   endproperty
   a_prog_mode: assert property (p_prog_mode) // R1
      else $error("programming mode does not follow the pin");

   property p_hidden_word;
      (state == ST_RDW && addrReg == `OB_ADDR_WORD && !progMode) |=> (hrdata == 32'h0);
   endproperty
   a_hidden_word: assert property (p_hidden_word) // R2
      else $error("option word visible outside programming mode");

   property p_burn_once;
      settled |-> (($past(fuseWord) & ~fuseWord) == 16'h0000);
   endproperty
   a_burn_once: assert property (p_burn_once) // R3
      else $error("a programmed bit was cleared");

   property p_blank;
      !everProgrammed |-> (fuseWord == 16'h0000);
   endproperty
   a_blank: assert property (p_blank) // R4
      else $error("blank part holds a set bit");

   property p_stop;
      (!cfg.extStop && watchdogNow) or (cfg.extStop && watchdogNow && !nmiPinHigh)
         |=> !stopAllowed;
   endproperty
   a_stop: assert property (p_stop) // R6
      else $error("stop allowed with watchdog active");

   property p_low_volt;
      settled |=> (cfg.lowVoltDetect == $past(effWord[`OB_BIT_LOW_VOLT]));
   endproperty
   a_low_volt: assert property (p_low_volt) // R7
      else $error("detector enable mismatch");

   property p_protect;
      cfg.readProtect ##1 cfg.readProtect |-> !extReadAllowed;
   endproperty
   a_protect: assert property (p_protect) // R8
      else $error("external read allowed while protected");

   property p_osc;
      settled |=> (cfg.rcOsc == $past(effWord[`OB_BIT_RC_OSC]));
   endproperty
   a_osc: assert property (p_osc) // R9
      else $error("oscillator select mismatch");

   property p_nmi_pull;
      settled |=> (cfg.nmiPullup == $past(effWord[`OB_BIT_NMI_PULL]));
   endproperty
   a_nmi_pull: assert property (p_nmi_pull) // R11
      else $error("nmi pull-up mismatch");

   property p_cnt_pull;
      settled |=> (cfg.counterPullup == $past(effWord[`OB_BIT_CNT_PULL]));
   endproperty
   a_cnt_pull: assert property (p_cnt_pull) // R12
      else $error("counter pull-up mismatch");

   property p_watchdog;
      cfg.hwWatchdog |=> watchdogEnable;
   endproperty
   a_watchdog: assert property (p_watchdog) // R13
      else $error("hardware watchdog not enabled");

   property p_guard;
      settled |=> (cfg.clockGuard == $past(effWord[`OB_BIT_CLK_GUARD]));
   endproperty
   a_guard: assert property (p_guard) // R14
      else $error("clock guard mismatch");

   property p_mask;
      (MASK_ROM && settled) |-> (cfgWord == MASK_CODE);
   endproperty
   a_mask: assert property (p_mask) // R15
      else $error("mask variant not using factory code");

   property p_stable;
      (settled && $past(settled) && !$past(progMode) && !$past(progMode, 2))
         |-> $stable(cfgWord);
   endproperty
   a_stable: assert property (p_stable) // R16
      else $error("configuration changed outside programming mode");

   property p_reprogram;
      progWrite |=> (fuseWord == ($past(fuseWord) | $past(hwdata[15:0])));
   endproperty
   a_reprogram: assert property (p_reprogram) // R17
      else $error("programming corrupted stored bits");

   property p_locked;
      (settled && !progMode) |=> $stable(fuseWord);
   endproperty
   a_locked: assert property (p_locked) // R2
      else $error("option word changed outside programming mode");

   property p_refuse;
      (wordWrite && !progMode) |=> rejectFlag;
   endproperty
   a_refuse: assert property (p_refuse) // R2
      else $error("refused option write not flagged");

   property p_mask_refuse;
      (MASK_ROM && wordWrite) |=> (rejectFlag && $stable(fuseWord));
   endproperty
   a_mask_refuse: assert property (p_mask_refuse) // R15
      else $error("mask variant accepted a programming write");

   property p_ext_read;
      settled && !cfg.readProtect ##1 !cfg.readProtect |-> extReadAllowed;
   endproperty
   a_ext_read: assert property (p_ext_read) // R8
      else $error("external read blocked while unprotected");

   property p_soft_watchdog;
      (!cfg.hwWatchdog && !softWatchdogEnable) |=> !watchdogEnable;
   endproperty
   a_soft_watchdog: assert property (p_soft_watchdog) // R13
      else $error("watchdog enabled without software request");

   property p_stop_ok;
      (cfg.extStop && nmiPinHigh) |=> stopAllowed;
   endproperty
   a_stop_ok: assert property (p_stop_ok) // R6
      else $error("stop refused with external control and pin high");

endmodule

// *** tb/prog_tool_model.sv ***
`timescale 1ns/100ps
module prog_tool_model #(
   parameter int RISE_DLY = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Request from the bench
   input wire logic enterProg,
   // Programming-voltage level
   output logic vppHigh
);
   int rampCnt;

   // Supply ramps up over a few cycles, drops at once
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rampCnt <= 0;
         vppHigh <= 1'b0;
      end else if (!enterProg) begin
         rampCnt <= 0;
         vppHigh <= 1'b0;
      end else if (rampCnt < RISE_DLY) begin
         rampCnt <= rampCnt + 1;
      end else begin
         vppHigh <= 1'b1;
      end
   end
endmodule

// *** tb/option_byte_config_tb.sv ***
`timescale 1ns/100ps
`include "option_byte_params.svh"
module option_byte_config_tb;
   import option_byte_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, enterProg = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic nmiPinHigh = 1'b0, softWatchdogEnable = 1'b0;
   logic hreadyout, hresp, vppHigh, stopAllowed, watchdogEnable, extReadAllowed;
   logic [31:0] hrdata;
   cfg_t cfg;
   cfg_t cfgRom;
   logic [31:0] hrdataRom, rdRom;
   logic stopRom, wdgRom, extRdRom;
   localparam logic [15:0] ROM_CODE = 16'h02d5; // Legal pattern, decodes to b5
   int miscompares = 0, checkCount = 0;

   // Clock
   always #25 ref_clk = ~ref_clk;

   option_byte_config u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vppHigh(vppHigh),
      .nmiPinHigh(nmiPinHigh), .softWatchdogEnable(softWatchdogEnable), .cfg(cfg),
      .stopAllowed(stopAllowed), .watchdogEnable(watchdogEnable),
      .extReadAllowed(extReadAllowed));

   // Factory-coded variant on the same bus; its ready output is left unused
   option_byte_config #(.MASK_ROM(1'b1), .MASK_CODE(ROM_CODE)) u_dut_rom (.ref_clk(ref_clk),
      .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(),
      .hrdata(hrdataRom), .vppHigh(vppHigh), .nmiPinHigh(nmiPinHigh),
      .softWatchdogEnable(softWatchdogEnable), .cfg(cfgRom), .stopAllowed(stopRom),
      .watchdogEnable(wdgRom), .extReadAllowed(extRdRom));

   prog_tool_model u_prog (.ref_clk(ref_clk), .arst_n(arst_n), .enterProg(enterProg),
      .vppHigh(vppHigh));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single AHB transfer, held until hready is sampled high
   task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      hsize <= `OB_HSIZE_WORD;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      rdRom = hrdataRom;
      chk({31'h0, hresp}, 32'h0);
   endtask

   // Legal word: reserved high bits clear, bit5 clear, bit4 set
   function automatic logic [31:0] legal(input logic [9:0] b);
      return {22'h0, b[9:6], 2'b01, b[3:0]};
   endfunction

   task automatic outs(input logic [7:0] c, input logic s, input logic w, input logic e);
      repeat (3) @(posedge ref_clk);
      chk({24'h0, cfg}, {24'h0, c});
      chk({29'h0, stopAllowed, watchdogEnable, extReadAllowed}, {29'h0, s, w, e});
   endtask

   task automatic t_blank();
      outs(8'h00, 1'b1, 1'b0, 1'b1);
      chk({24'h0, cfgRom}, 32'hb5);
      chk({29'h0, stopRom, wdgRom, extRdRom}, 32'h4);
      ahb(1'b0, `OB_ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk(rdRom, 32'h2);
      $display("test blank done");
   endtask

   task automatic t_locked();
      ahb(1'b1, `OB_ADDR_WORD, legal(10'h3cf));
      ahb(1'b0, `OB_ADDR_WORD, 32'h0);
      chk(rd, 32'h0);
      chk(rdRom, 32'h0);
      outs(8'h00, 1'b1, 1'b0, 1'b1);
      ahb(1'b0, `OB_ADDR_STATUS, 32'h0);
      chk(rd, 32'h4);
      chk(rdRom, 32'h6);
      ahb(1'b1, `OB_ADDR_STATUS, 32'h4);
      ahb(1'b0, `OB_ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk(rdRom, 32'h2);
      $display("test locked done");
   endtask

   task automatic t_program();
      enterProg <= 1'b1;
      repeat (6) @(posedge ref_clk);
      ahb(1'b0, `OB_ADDR_STATUS, 32'h0);
      chk(rd, 32'h1);
      chk(rdRom, 32'h3);
      softWatchdogEnable <= 1'b1;
      ahb(1'b1, `OB_ADDR_WORD, legal(10'h280));
      ahb(1'b0, `OB_ADDR_WORD, 32'h0);
      chk(rd, 32'h290);
      chk(rdRom, {16'h0, ROM_CODE});
      outs(8'ha0, 1'b0, 1'b1, 1'b0);
      chk({24'h0, cfgRom}, 32'hb5);
      nmiPinHigh <= 1'b1;
      outs(8'ha0, 1'b1, 1'b1, 1'b0);
      $display("test program done");
   endtask

   task automatic t_burnt();
      ahb(1'b1, `OB_ADDR_WORD, 32'h0);
      ahb(1'b0, `OB_ADDR_WORD, 32'h0);
      chk(rd, 32'h290);
      softWatchdogEnable <= 1'b0;
      nmiPinHigh <= 1'b0;
      ahb(1'b1, `OB_ADDR_WORD, legal(10'h14f));
      outs(8'hff, 1'b0, 1'b1, 1'b0);
      ahb(1'b1, `OB_ADDR_WORD, 32'h400);
      ahb(1'b0, `OB_ADDR_WORD, 32'h0);
      chk(rd, 32'h7df);
      ahb(1'b0, `OB_ADDR_STATUS, 32'h0);
      chk(rd, 32'h9);
      chk(rdRom, 32'h7);
      $display("test burnt done");
   endtask

   task automatic t_exit();
      enterProg <= 1'b0;
      repeat (3) @(posedge ref_clk);
      ahb(1'b0, `OB_ADDR_WORD, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, 32'h8, 32'hffff_ffff);
      ahb(1'b0, 32'h8, 32'h0);
      chk(rd, 32'h0);
      outs(8'hff, 1'b0, 1'b1, 1'b0);
      $display("test exit done");
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_blank();
      t_locked();
      t_program();
      t_burnt();
      t_exit();
      report_and_stop();
   end

   // Hang guard
   initial begin
      repeat (3000) @(posedge ref_clk);
      miscompares++;
      report_and_stop();
   end
endmodule
